// *** hw/rwic_consts.vh ***
`ifndef RWIC_CONSTS_VH
`define RWIC_CONSTS_VH

// Register offsets
`define ADDR_CORE_STATUS 4'h3
`define ADDR_WAKE 4'he
`define ADDR_IRQ 4'hf

// Field positions
`define CS_TIMEOUT 4
`define CS_PDOWN 3
`define WAKE_CHANGE 1
`define WDO_ENABLE 7
`define WDO_EXT_SEL 6
`define IRQ_TIMER 0
`define IRQ_CHANGE 1
`define IRQ_EXT 2

// Reset values and writable masks
`define WDO_RESET 8'h80
`define WDO_WMASK 8'hdf
`define WAKE_WMASK 8'h02
`define GP_WMASK 8'he0

// Vectors
`define VEC_IRQ 10'h008
`define VEC_SOFT 10'h001

// Reset hold time after a reset cause, 18 ms of 100 MHz cycles
`define HOLD_CYCLES 21'd1800000
`endif

// *** hw/port6_change_detect.v ***
`timescale 1ns/1ps
module port6_change_detect #(
    parameter W = 8
) (
    input wire clk,
    input wire ce,
    input wire rst_n,
    input wire ref_load,
    input wire [W-1:0] pins,
    input wire [W-1:0] is_input,
    input wire pin0_is_int,
    output reg change
);
    reg [W-1:0] ref_val;
    wire [W-1:0] watch;

    // Outputs and the interrupt pin take no part
    assign watch = is_input & ~{{(W-1){1'b0}}, pin0_is_int};

    // Reference taken on a port read, compared pin by pin
    always @(posedge clk) begin
        if (!rst_n) begin
            ref_val <= {W{1'b0}};
            change <= 1'b0;
        end else if (ce) begin
            if (ref_load) begin
                ref_val <= pins;
            end
            change <= |((pins ^ ref_val) & watch) & ~ref_load;
        end
    end
endmodule

// *** hw/reset_wake_interrupt_ctrl.v ***
`timescale 1ns/1ps
`include "rwic_consts.vh"
module reset_wake_interrupt_ctrl #(
    parameter HOLD_W = 21,
    parameter [HOLD_W-1:0] HOLD_CYCLES = `HOLD_CYCLES
) (
    input wire CLK,
    input wire RST_N,
    input wire CE,
    input wire RESET_PIN_N,
    input wire WDT_EXPIRE,
    input wire TIMER_OVF_N,
    input wire [7:0] PORT6_IN,
    input wire [7:0] PORT6_IS_INPUT,
    input wire PORT6_READ,
    input wire SLEEP_INSTR,
    input wire WDT_CLEAR_INSTR,
    input wire IRQ_ON_INSTR,
    input wire IRQ_OFF_INSTR,
    input wire IRQ_RETURN_INSTR,
    input wire SOFT_IRQ_INSTR,
    input wire [3:0] REG_ADDR,
    input wire REG_CTRL_SPACE,
    input wire REG_WR,
    input wire REG_RD,
    input wire [7:0] REG_WDATA,
    output reg [7:0] REG_RDATA,
    output wire CORE_RESET,
    output wire SLEEPING,
    output reg WAKE_CONTINUE,
    output reg VECTOR_VALID,
    output reg [9:0] VECTOR_ADDR,
    output reg GLOBAL_IRQ_EN,
    output wire WDT_ENABLE,
    output reg WDT_CLEAR
);
    localparam [1:0] ST_HOLD = 2'h0;
    localparam [1:0] ST_RUN = 2'h1;
    localparam [1:0] ST_SLEEP = 2'h2;

    reg [1:0] state;
    reg [HOLD_W-1:0] hold_cnt;
    reg timeout_flag;
    reg powerdown_flag;
    reg [2:0] gp_bits;
    reg pin_change_wake_en;
    reg [7:0] watchdog_option_reg;
    reg [2:0] irq_flags;
    reg [2:0] irq_mask;
    reg timer_prev;
    reg ext_prev;
    reg [2:0] next_flags;
    reg [7:0] read_val;
    reg [1:0] next_state;
    reg [HOLD_W-1:0] next_hold;
    reg next_timeout;
    reg next_powerdown;
    wire pin_change;
    wire ext_sel;
    wire active;
    wire wr_core;
    wire wr_wake;
    wire wr_wdo;
    wire wr_flags;
    wire wr_mask;
    wire [2:0] pending;
    wire wdt_reset;
    wire core_init;
    wire running;
    wire hold_done;
    wire change_wake;

    // Falling edge of a level sampled one cycle apart
    function fell;
        input prev;
        input cur;
        begin
            fell = prev & ~cur;
        end
    endfunction

    // Register select, control space chosen by REG_CTRL_SPACE
    function hit;
        input [3:0] addr;
        input ctrl;
        input [3:0] want;
        input want_ctrl;
        begin
            hit = (addr == want) && (ctrl == want_ctrl);
        end
    endfunction

    assign ext_sel = watchdog_option_reg[`WDO_EXT_SEL];
    assign WDT_ENABLE = watchdog_option_reg[`WDO_ENABLE];
    assign active = (state == ST_RUN) || (state == ST_SLEEP);
    assign CORE_RESET = (state == ST_HOLD);
    assign SLEEPING = (state == ST_SLEEP);

    // Reset causes, run state, hold end and change wake
    assign wdt_reset = WDT_EXPIRE & WDT_ENABLE & active;
    assign core_init = ~RESET_PIN_N | wdt_reset;
    assign running = (state == ST_RUN);
    assign hold_done = (hold_cnt >= HOLD_CYCLES - 1'b1);
    assign change_wake = SLEEPING & pin_change & pin_change_wake_en;

    // Write strobes, ignored while the core is held in reset
    assign wr_core = REG_WR & running & hit(REG_ADDR, REG_CTRL_SPACE, `ADDR_CORE_STATUS, 1'b0);
    assign wr_wake = REG_WR & running & hit(REG_ADDR, REG_CTRL_SPACE, `ADDR_WAKE, 1'b0);
    assign wr_wdo = REG_WR & running & hit(REG_ADDR, REG_CTRL_SPACE, `ADDR_WAKE, 1'b1);
    assign wr_flags = REG_WR & running & hit(REG_ADDR, REG_CTRL_SPACE, `ADDR_IRQ, 1'b0);
    assign wr_mask = REG_WR & running & hit(REG_ADDR, REG_CTRL_SPACE, `ADDR_IRQ, 1'b1);

    // Masked requests seen by the vector logic
    assign pending = irq_flags & irq_mask;

    // Port 6 comparison against the reference latched on a read
    port6_change_detect #(
        .W(8)
    ) u_change (
        .clk(CLK),
        .ce(CE),
        .rst_n(RST_N & ~CORE_RESET),
        .ref_load(PORT6_READ),
        .pins(PORT6_IN),
        .is_input(PORT6_IS_INPUT),
        .pin0_is_int(ext_sel),
        .change(pin_change)
    );

    // Flag update: firmware write first, then hardware sets win
    always @* begin
        next_flags = irq_flags;
        if (wr_flags) begin
            next_flags = REG_WDATA[2:0];
        end
        if (fell(timer_prev, TIMER_OVF_N)) begin
            next_flags[`IRQ_TIMER] = 1'b1;
        end
        if (ext_sel && fell(ext_prev, PORT6_IN[0])) begin
            next_flags[`IRQ_EXT] = 1'b1;
        end
        if (pin_change && irq_mask[`IRQ_CHANGE]) begin
            next_flags[`IRQ_CHANGE] = 1'b1;
        end
    end

    // Read data mux; unused bits read zero
    always @* begin
        read_val = 8'h00;
        if (hit(REG_ADDR, REG_CTRL_SPACE, `ADDR_CORE_STATUS, 1'b0)) begin
            read_val = {gp_bits, timeout_flag, powerdown_flag, 3'h0};
        end else if (hit(REG_ADDR, REG_CTRL_SPACE, `ADDR_WAKE, 1'b0)) begin
            read_val[`WAKE_CHANGE] = pin_change_wake_en;
        end else if (hit(REG_ADDR, REG_CTRL_SPACE, `ADDR_WAKE, 1'b1)) begin
            read_val = watchdog_option_reg;
        end else if (hit(REG_ADDR, REG_CTRL_SPACE, `ADDR_IRQ, 1'b0)) begin
            read_val = {5'h00, irq_flags & irq_mask};
        end else if (hit(REG_ADDR, REG_CTRL_SPACE, `ADDR_IRQ, 1'b1)) begin
            read_val = {5'h00, irq_mask};
        end
    end

    // Edge history for the falling-edge sources
    always @(posedge CLK) begin
        if (!RST_N) begin
            timer_prev <= 1'b1;
            ext_prev <= 1'b1;
        end else if (CE) begin
            timer_prev <= TIMER_OVF_N;
            ext_prev <= PORT6_IN[0];
        end
    end

    // Registered read data
    always @(posedge CLK) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
        end else if (CE && REG_RD) begin
            REG_RDATA <= read_val;
        end
    end

    // Next sequencer state and hold count
    always @* begin
        next_state = state;
        next_hold = hold_cnt;
        if (core_init) begin
            // Clear pin low or armed expiry restarts the hold
            next_state = ST_HOLD;
            next_hold = {HOLD_W{1'b0}};
        end else begin
            case (state)
                ST_HOLD: begin
                    // Stretch every reset cause to the hold time
                    if (hold_done) begin
                        next_state = ST_RUN;
                        next_hold = {HOLD_W{1'b0}};
                    end else begin
                        next_hold = hold_cnt + 1'b1;
                    end
                end
                ST_RUN: begin
                    if (SLEEP_INSTR) begin
                        next_state = ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (change_wake) begin
                        // Change wake resumes program flow
                        next_state = ST_RUN;
                    end
                end
                default: begin
                    next_state = ST_HOLD;
                    next_hold = {HOLD_W{1'b0}};
                end
            endcase
        end
    end

    // Timeout and powerdown flags after each event
    always @* begin
        next_timeout = timeout_flag;
        next_powerdown = powerdown_flag;
        if (!RESET_PIN_N) begin
            // Running: both kept; sleeping: wake pattern
            if (state == ST_SLEEP) begin
                next_timeout = 1'b1;
                next_powerdown = 1'b0;
            end
        end else if (wdt_reset) begin
            next_timeout = 1'b0;
            if (state == ST_SLEEP) begin
                next_powerdown = 1'b0;
            end
        end else if (running && SLEEP_INSTR) begin
            next_timeout = 1'b1;
            next_powerdown = 1'b0;
        end else if (running && WDT_CLEAR_INSTR) begin
            next_timeout = 1'b1;
            next_powerdown = 1'b1;
        end else if (change_wake) begin
            next_timeout = 1'b1;
            next_powerdown = 1'b0;
        end
    end

    // Sequencer state and status flags
    always @(posedge CLK) begin
        if (!RST_N) begin
            state <= ST_HOLD;
            hold_cnt <= {HOLD_W{1'b0}};
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
        end else if (CE) begin
            state <= next_state;
            hold_cnt <= next_hold;
            timeout_flag <= next_timeout;
            powerdown_flag <= next_powerdown;
        end
    end

    // Firmware registers, re-initialised by every reset cause
    always @(posedge CLK) begin
        if (!RST_N) begin
            gp_bits <= 3'h0;
            pin_change_wake_en <= 1'b0;
            watchdog_option_reg <= `WDO_RESET;
            irq_flags <= 3'h0;
            irq_mask <= 3'h0;
        end else if (CE) begin
            if (core_init) begin
                gp_bits <= 3'h0;
                pin_change_wake_en <= 1'b0;
                watchdog_option_reg <= `WDO_RESET;
                irq_flags <= 3'h0;
                irq_mask <= 3'h0;
            end else if (active) begin
                // Flags keep latching in sleep; writes only come while running
                irq_flags <= next_flags;
                if (wr_core) begin
                    gp_bits <= REG_WDATA[7:5];
                end
                if (wr_wake) begin
                    pin_change_wake_en <= REG_WDATA[`WAKE_CHANGE];
                end
                if (wr_wdo) begin
                    watchdog_option_reg <= REG_WDATA & `WDO_WMASK;
                end
                if (wr_mask) begin
                    irq_mask <= REG_WDATA[2:0];
                end
            end
        end
    end

    // Global enable, vectors and one-cycle pulses
    always @(posedge CLK) begin
        if (!RST_N) begin
            GLOBAL_IRQ_EN <= 1'b0;
            WAKE_CONTINUE <= 1'b0;
            VECTOR_VALID <= 1'b0;
            VECTOR_ADDR <= 10'h000;
            WDT_CLEAR <= 1'b0;
        end else if (CE) begin
            WAKE_CONTINUE <= 1'b0;
            VECTOR_VALID <= 1'b0;
            WDT_CLEAR <= 1'b0;
            if (core_init) begin
                GLOBAL_IRQ_EN <= 1'b0;
            end else if (running) begin
                if (SOFT_IRQ_INSTR) begin
                    VECTOR_VALID <= 1'b1;
                    VECTOR_ADDR <= `VEC_SOFT;
                    GLOBAL_IRQ_EN <= 1'b0;
                end else if (GLOBAL_IRQ_EN && (|pending)) begin
                    VECTOR_VALID <= 1'b1;
                    VECTOR_ADDR <= `VEC_IRQ;
                    GLOBAL_IRQ_EN <= 1'b0;
                end else if (IRQ_ON_INSTR || IRQ_RETURN_INSTR) begin
                    GLOBAL_IRQ_EN <= 1'b1;
                end else if (IRQ_OFF_INSTR) begin
                    GLOBAL_IRQ_EN <= 1'b0;
                end
                if (SLEEP_INSTR || WDT_CLEAR_INSTR) begin
                    // Sleep entry also clears the watchdog count
                    WDT_CLEAR <= 1'b1;
                end
            end else if (change_wake) begin
                if (!(GLOBAL_IRQ_EN && irq_mask[`IRQ_CHANGE])) begin
                    WAKE_CONTINUE <= 1'b1;
                end
            end
        end
    end
endmodule

// *** tb/rwic_checker.sv ***
`timescale 1ns/1ps
module rwic_checker (
    input wire CLK,
    input wire RST_N,
    input wire CE,
    input wire RESET_PIN_N,
    input wire WDT_EXPIRE,
    input wire SLEEP_INSTR,
    input wire WDT_CLEAR_INSTR,
    input wire IRQ_ON_INSTR,
    input wire IRQ_OFF_INSTR,
    input wire IRQ_RETURN_INSTR,
    input wire SOFT_IRQ_INSTR,
    input wire CORE_RESET,
    input wire SLEEPING,
    input wire WAKE_CONTINUE,
    input wire VECTOR_VALID,
    input wire [9:0] VECTOR_ADDR,
    input wire GLOBAL_IRQ_EN,
    input wire WDT_ENABLE,
    input wire WDT_CLEAR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // Core is executing instructions
    wire run = CE && !CORE_RESET && !SLEEPING;
    a_soft_vector: assert property (run && SOFT_IRQ_INSTR |=> VECTOR_VALID && VECTOR_ADDR == 10'h001)
        else $error("soft interrupt did not vector to 001");
    a_irq_vector: assert property (VECTOR_VALID && !$past(SOFT_IRQ_INSTR) |-> VECTOR_ADDR == 10'h008 && $past(GLOBAL_IRQ_EN))
        else $error("hardware vector wrong address or without global enable");
    a_vector_gie: assert property (VECTOR_VALID |-> !GLOBAL_IRQ_EN)
        else $error("global enable still set while vectoring");
    a_gie_on: assert property (run && IRQ_ON_INSTR |=> GLOBAL_IRQ_EN || VECTOR_VALID)
        else $error("enable instruction did not set global enable");
    a_gie_off: assert property (run && IRQ_OFF_INSTR |=> !GLOBAL_IRQ_EN)
        else $error("disable instruction did not clear global enable");
    a_return_gie: assert property (run && IRQ_RETURN_INSTR |=> GLOBAL_IRQ_EN || VECTOR_VALID)
        else $error("return did not set global enable");
    a_sleep_entry: assert property (run && SLEEP_INSTR |=> SLEEPING && WDT_CLEAR)
        else $error("sleep entry without sleeping state or watchdog clear");
    a_watchdog_clear_instr_clear: assert property (run && WDT_CLEAR_INSTR |=> WDT_CLEAR)
        else $error("watchdog clear instruction gave no clear pulse");
    a_pin_reset: assert property (CE && !RESET_PIN_N |=> CORE_RESET)
        else $error("clear pin did not hold the core in reset");
    a_wdt_reset: assert property (CE && WDT_EXPIRE && WDT_ENABLE && !CORE_RESET |=> CORE_RESET)
        else $error("watchdog expiry did not reset the core");
    a_wake_cont: assert property (WAKE_CONTINUE |-> $past(SLEEPING) && !SLEEPING)
        else $error("continue pulse without leaving sleep");
    c_hw_vector: cover property (VECTOR_VALID && VECTOR_ADDR == 10'h008);
    c_wake: cover property (WAKE_CONTINUE);
    c_wdt: cover property (SLEEPING && WDT_EXPIRE);
endmodule
bind reset_wake_interrupt_ctrl rwic_checker u_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE), .RESET_PIN_N(RESET_PIN_N),
    .WDT_EXPIRE(WDT_EXPIRE), .SLEEP_INSTR(SLEEP_INSTR), .WDT_CLEAR_INSTR(WDT_CLEAR_INSTR),
    .IRQ_ON_INSTR(IRQ_ON_INSTR), .IRQ_OFF_INSTR(IRQ_OFF_INSTR), .IRQ_RETURN_INSTR(IRQ_RETURN_INSTR),
    .SOFT_IRQ_INSTR(SOFT_IRQ_INSTR), .CORE_RESET(CORE_RESET), .SLEEPING(SLEEPING),
    .WAKE_CONTINUE(WAKE_CONTINUE), .VECTOR_VALID(VECTOR_VALID), .VECTOR_ADDR(VECTOR_ADDR),
    .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .WDT_ENABLE(WDT_ENABLE), .WDT_CLEAR(WDT_CLEAR));

// *** tb/fw_model.sv ***
`timescale 1ns/1ps
module fw_model (
    input wire [2:0] op,
    output wire sleep_i,
    output wire clr_i,
    output wire on_i,
    output wire off_i,
    output wire ret_i,
    output wire soft_i
);
    // Firmware executes one instruction per cycle, so at most one pulse
    assign sleep_i = op == 3'h1;
    assign clr_i = op == 3'h2;
    assign on_i = op == 3'h3;
    assign off_i = op == 3'h4;
    assign ret_i = op == 3'h5;
    assign soft_i = op == 3'h6;
endmodule

// *** tb/tb_reset_wake_interrupt_ctrl.sv ***
`timescale 1ns/1ps
module tb_reset_wake_interrupt_ctrl;
    logic CLK = 0, RST_N = 0, CE = 1, RESET_PIN_N = 1, WDT_EXPIRE = 0, TIMER_OVF_N = 1, PORT6_READ = 0;
    logic [7:0] PORT6_IN = 8'hff, PORT6_IS_INPUT = 8'hfe, REG_WDATA = 8'h00, REG_RDATA;
    logic [3:0] REG_ADDR = 4'h0;
    logic REG_CTRL_SPACE = 0, REG_WR = 0, REG_RD = 0;
    logic [2:0] op = 3'h0;
    logic [9:0] VECTOR_ADDR;
    logic SLEEP_INSTR, WDT_CLEAR_INSTR, IRQ_ON_INSTR, IRQ_OFF_INSTR, IRQ_RETURN_INSTR, SOFT_IRQ_INSTR;
    logic CORE_RESET, SLEEPING, WAKE_CONTINUE, VECTOR_VALID, GLOBAL_IRQ_EN, WDT_ENABLE, WDT_CLEAR;
    int errors = 0, n_checks = 0;
    always #5 CLK = ~CLK;
    fw_model u_fw (.op(op), .sleep_i(SLEEP_INSTR), .clr_i(WDT_CLEAR_INSTR), .on_i(IRQ_ON_INSTR),
        .off_i(IRQ_OFF_INSTR), .ret_i(IRQ_RETURN_INSTR), .soft_i(SOFT_IRQ_INSTR));
    reset_wake_interrupt_ctrl #(.HOLD_W(21), .HOLD_CYCLES(21'd8)) dut (.CLK(CLK), .RST_N(RST_N), .CE(CE),
        .RESET_PIN_N(RESET_PIN_N), .WDT_EXPIRE(WDT_EXPIRE), .TIMER_OVF_N(TIMER_OVF_N), .PORT6_IN(PORT6_IN),
        .PORT6_IS_INPUT(PORT6_IS_INPUT), .PORT6_READ(PORT6_READ), .SLEEP_INSTR(SLEEP_INSTR),
        .WDT_CLEAR_INSTR(WDT_CLEAR_INSTR), .IRQ_ON_INSTR(IRQ_ON_INSTR), .IRQ_OFF_INSTR(IRQ_OFF_INSTR),
        .IRQ_RETURN_INSTR(IRQ_RETURN_INSTR), .SOFT_IRQ_INSTR(SOFT_IRQ_INSTR), .REG_ADDR(REG_ADDR),
        .REG_CTRL_SPACE(REG_CTRL_SPACE), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_WDATA(REG_WDATA),
        .REG_RDATA(REG_RDATA), .CORE_RESET(CORE_RESET), .SLEEPING(SLEEPING), .WAKE_CONTINUE(WAKE_CONTINUE),
        .VECTOR_VALID(VECTOR_VALID), .VECTOR_ADDR(VECTOR_ADDR), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
        .WDT_ENABLE(WDT_ENABLE), .WDT_CLEAR(WDT_CLEAR));
    // Helpers, all acting on falling edges
    task nx(input int n);
        repeat (n) @(negedge CLK);
    endtask
    task complete_run;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [9:0] got, input logic [9:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            errors++;
        end
    endtask
    task give_up;
        $display("ERROR t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        errors++;
        complete_run;
    endtask
    task wr(input logic s, input logic [3:0] a, input logic [7:0] d);
        REG_CTRL_SPACE = s;
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WR = 1;
        nx(1);
        REG_WR = 0;
        nx(1);
    endtask
    task rd(input logic s, input logic [3:0] a, input logic [7:0] e);
        REG_CTRL_SPACE = s;
        REG_ADDR = a;
        REG_RD = 1;
        nx(1);
        REG_RD = 0;
        nx(1);
        chk(10'(REG_RDATA), 10'(e));
    endtask
    task fw(input logic [2:0] o);
        op = o;
        nx(1);
        op = 3'h0;
        nx(1);
    endtask
    task p6rd;
        PORT6_READ = 1;
        nx(1);
        PORT6_READ = 0;
    endtask
    task waitp(input logic w);
        for (int i = 0; i < 6; i++) begin
            if ((w ? WAKE_CONTINUE : VECTOR_VALID) === 1'b1)
                return;
            nx(1);
        end
        give_up;
    endtask
    task wait_run;
        nx(1);
        for (int i = 0; i < 40; i++) begin
            if (CORE_RESET === 1'b0)
                return;
            nx(1);
        end
        give_up;
    endtask
    task pin_rst;
        RESET_PIN_N = 0;
        nx(2);
        RESET_PIN_N = 1;
        wait_run;
    endtask
    // Reset values, read-only status bits, unmapped offset
    task t_por;
        rd(0, 4'h3, 8'h18);
        chk(10'(WDT_ENABLE), 10'h001);
        rd(1, 4'he, 8'h80);
        rd(0, 4'h5, 8'h00);
        wr(0, 4'h3, 8'hff);
        rd(0, 4'h3, 8'hf8);
        wr(0, 4'h3, 8'h00);
        $display("test por done");
    endtask
    // Masked timer and external flags still set, read back gated by mask
    task t_flags;
        wr(1, 4'he, 8'hc0);
        TIMER_OVF_N = 0;
        PORT6_IN = 8'hfe;
        nx(3);
        rd(0, 4'hf, 8'h00);
        wr(1, 4'hf, 8'h05);
        rd(0, 4'hf, 8'h05);
        TIMER_OVF_N = 1;
        PORT6_IN = 8'hff;
        wr(0, 4'hf, 8'h00);
        rd(0, 4'hf, 8'h00);
        $display("test flags done");
    endtask
    // Global enable, hardware and soft vectors
    task t_vec;
        fw(3'h3);
        chk(10'(GLOBAL_IRQ_EN), 10'h001);
        fw(3'h4);
        chk(10'(GLOBAL_IRQ_EN), 10'h000);
        fw(3'h3);
        wr(1, 4'hf, 8'h01);
        TIMER_OVF_N = 0;
        waitp(0);
        chk(VECTOR_ADDR, 10'h008);
        chk(10'(GLOBAL_IRQ_EN), 10'h000);
        TIMER_OVF_N = 1;
        wr(0, 4'hf, 8'h00);
        fw(3'h5);
        chk(10'(GLOBAL_IRQ_EN), 10'h001);
        op = 3'h6;
        nx(1);
        op = 3'h0;
        chk(10'(VECTOR_VALID), 10'h001);
        chk(VECTOR_ADDR, 10'h001);
        chk(10'(GLOBAL_IRQ_EN), 10'h000);
        $display("test vec done");
    endtask
    // Pin-change wake, first continuing, then vectoring
    task t_sleep;
        wr(1, 4'he, 8'h40);
        p6rd;
        wr(1, 4'hf, 8'h02);
        wr(0, 4'he, 8'h02);
        fw(3'h4);
        fw(3'h1);
        chk(10'(SLEEPING), 10'h001);
        PORT6_IN = 8'hfe;
        nx(3);
        chk(10'(SLEEPING), 10'h001);
        PORT6_IN = 8'hf6;
        waitp(1);
        rd(0, 4'h3, 8'h10);
        p6rd;
        wr(0, 4'hf, 8'h00);
        fw(3'h3);
        fw(3'h1);
        PORT6_IN = 8'hff;
        waitp(0);
        chk(VECTOR_ADDR, 10'h008);
        p6rd;
        wr(0, 4'hf, 8'h00);
        $display("test sleep done");
    endtask
    // Reset causes and the status flags they leave
    task t_rst;
        pin_rst;
        rd(0, 4'h3, 8'h10);
        fw(3'h2);
        rd(0, 4'h3, 8'h18);
        WDT_EXPIRE = 1;
        nx(1);
        WDT_EXPIRE = 0;
        chk(10'(CORE_RESET), 10'h001);
        wait_run;
        rd(0, 4'h3, 8'h08);
        fw(3'h1);
        WDT_EXPIRE = 1;
        nx(1);
        WDT_EXPIRE = 0;
        wait_run;
        rd(0, 4'h3, 8'h00);
        fw(3'h1);
        pin_rst;
        rd(0, 4'h3, 8'h10);
        $display("test rst done");
    endtask
    // Main sequence
    initial begin
        nx(6);
        RST_N = 1;
        wait_run;
        t_por;
        t_flags;
        t_vec;
        t_sleep;
        t_rst;
        complete_run;
    end
endmodule
